// ==== core/adc_autocal_sequencer.sv ====
// sequencer for calibration and 16-bit successive-approximation conversion
// assumes master clock, strobe, request and comparator pins synchronous to sys_clk_in
`include "adc_cal_map.svh"

module adc_autocal_sequencer #(
  parameter logic [`CAL_CNT_W-1:0] CAL_CYCLES = `CAL_CNT_W'(`CAL_MCLK_CYCLES)
) (
  input wire logic sys_clk_in, // system clock, 250 MHz
  input wire logic srst_in, // sync reset, active high
  input wire logic cal_req_in, // calibration request pin
  input wire logic sample_in, // acquisition strobe pin
  input wire logic mclk_in, // master clock pin
  input wire logic cmp_in, // comparator decision, high keeps trial bit
  output logic busy_out, // conversion or calibration in progress
  output logic serial_result_out, // bit decisions, msb first
  output logic [`RESULT_W-1:0] result_out, // corrected result
  output logic result_valid_out, // one-cycle pulse with new result
  output logic [`RESULT_W-1:0] sar_code_out, // main array trial code
  output logic track_out, // sample-hold tracking input
  output logic gnd_sense_sel_out, // input tied to ground sense
  output logic [3:0] cap_sel_out, // capacitor under test, 0 none
  output logic [`CORR_W-1:0] cal_dac_out, // calibration dac code
  output logic calibrated_out // a calibration has completed
);

  // ----------------------------------------
  // pin history and edges
  // ----------------------------------------
  logic mclk_q, mclk_d;
  logic sample_q, sample_d;
  logic mclk_rise, sample_fall;

  always_comb begin
    mclk_d = mclk_in;
    sample_d = sample_in;
    mclk_rise = mclk_in & ~mclk_q;
    sample_fall = sample_q & ~sample_in;
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      mclk_q <= 1'b0;
      sample_q <= 1'b0;
    end else begin
      mclk_q <= mclk_d;
      sample_q <= sample_d;
    end
  end

  // ----------------------------------------
  // correction memory
  // ----------------------------------------
  logic ram_we;
  logic [`COEF_ADDR_W-1:0] ram_waddr, ram_raddr;
  logic [`CORR_W-1:0] ram_wdata, ram_rdata;

  cal_coef_ram u_coef (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .wr_en_in(ram_we),
    .wr_addr_in(ram_waddr),
    .wr_data_in(ram_wdata),
    .rd_addr_in(ram_raddr),
    .rd_data_out(ram_rdata)
  );

  // ----------------------------------------
  // sequencer state
  // ----------------------------------------
  adc_cal_pkg::seq_state_e state_q, state_d;
  logic busy_q, busy_d;
  logic calibrated_q, calibrated_d;
  logic [`CAL_CNT_W-1:0] cal_cnt_q, cal_cnt_d;
  logic [3:0] step_q, step_d;
  logic [`CORR_W-1:0] corr_code_q, corr_code_d, corr_mask_q, corr_mask_d;
  logic [`RESULT_W-1:0] sar_q, sar_d, mask_q, mask_d;
  logic [4:0] edges_q, edges_d;
  logic signed [`RESULT_W:0] acc_q, acc_d;
  logic [`RESULT_W-1:0] result_q, result_d;
  logic valid_q, valid_d;
  logic sdo_q, sdo_d;
  logic track_q, track_d;
  logic gnd_q, gnd_d;
  logic [3:0] cap_q, cap_d;
  logic [`CORR_W-1:0] kept_corr;
  logic [`RESULT_W-1:0] kept_sar;
  logic signed [`RESULT_W+1:0] diff;
  logic top_bit;

  always_comb begin
    state_d = state_q;
    calibrated_d = calibrated_q;
    cal_cnt_d = cal_cnt_q;
    step_d = step_q;
    corr_code_d = corr_code_q;
    corr_mask_d = corr_mask_q;
    sar_d = sar_q;
    mask_d = mask_q;
    edges_d = edges_q;
    acc_d = acc_q;
    result_d = result_q;
    valid_d = 1'b0;
    sdo_d = sdo_q;
    ram_we = 1'b0;
    ram_waddr = step_q;
    ram_wdata = corr_code_q;
    ram_raddr = `OFFSET_ENTRY;
    kept_corr = cmp_in ? corr_code_q : (corr_code_q & ~corr_mask_q);
    kept_sar = cmp_in ? sar_q : (sar_q & ~mask_q);
    top_bit = (edges_q < 5'(`CORR_TOP_BITS));
    diff = $signed({2'b00, sar_q}) - $signed({acc_q[`RESULT_W], acc_q});
    case (state_q)
      adc_cal_pkg::ST_IDLE: begin
        if (sample_fall) begin
          state_d = adc_cal_pkg::ST_CONV;
          sar_d = 16'h8000;
          mask_d = 16'h8000;
          edges_d = 5'h00;
          acc_d = (`RESULT_W+1)'($signed(ram_rdata));
        end
      end
      adc_cal_pkg::ST_HOLD: begin
        if (!cal_req_in) begin
          state_d = adc_cal_pkg::ST_CAL;
        end
      end
      adc_cal_pkg::ST_CAL: begin
        if (mclk_rise) begin
          cal_cnt_d = cal_cnt_q + `CAL_CNT_W'(1);
          if (step_q <= `CAL_STEPS) begin
            sdo_d = cmp_in;
            corr_code_d = kept_corr;
            corr_mask_d = corr_mask_q >> 1;
            if (corr_mask_q[0]) begin
              ram_we = 1'b1;
              ram_wdata = kept_corr;
              step_d = step_q + 4'h1;
              corr_code_d = 8'h80;
              corr_mask_d = 8'h80;
            end else begin
              corr_code_d = kept_corr | (corr_mask_q >> 1);
            end
          end
          if (cal_cnt_q == CAL_CYCLES - `CAL_CNT_W'(1)) begin
            state_d = adc_cal_pkg::ST_IDLE;
            calibrated_d = 1'b1;
          end
        end
      end
      adc_cal_pkg::ST_CONV: begin
        // park on the offset entry after the last bit, ready for a back-to-back start
        ram_raddr = (edges_q < `CONV_EDGES) ? 4'(edges_q) + 4'h1 : `OFFSET_ENTRY;
        if (mclk_rise) begin
          edges_d = edges_q + 5'h01;
          if (edges_q < `CONV_EDGES) begin
            sdo_d = cmp_in;
            sar_d = kept_sar | (mask_q >> 1);
            mask_d = mask_q >> 1;
            if (top_bit && cmp_in) begin
              acc_d = acc_q + (`RESULT_W+1)'($signed(ram_rdata));
            end
          end else begin
            state_d = adc_cal_pkg::ST_IDLE;
            valid_d = 1'b1;
            if (diff > 18'sh07fff) begin
              result_d = 16'h7fff;
            end else if (diff < -18'sh08000) begin
              result_d = 16'h8000;
            end else begin
              result_d = diff[`RESULT_W-1:0];
            end
          end
        end
      end
      default: begin
        state_d = adc_cal_pkg::ST_HOLD;
      end
    endcase
    if (cal_req_in) begin
      state_d = adc_cal_pkg::ST_HOLD;
      cal_cnt_d = '0;
      step_d = `OFFSET_ENTRY;
      corr_code_d = 8'h80;
      corr_mask_d = 8'h80;
      sar_d = '0;
      mask_d = '0;
      edges_d = '0;
      acc_d = '0;
      calibrated_d = 1'b0;
      sdo_d = 1'b0;
      valid_d = 1'b0;
    end
    busy_d = (state_d != adc_cal_pkg::ST_IDLE);
    track_d = (state_d == adc_cal_pkg::ST_IDLE) && sample_in;
    gnd_d = (state_d == adc_cal_pkg::ST_CAL) && (step_d == `OFFSET_ENTRY);
    cap_d = (state_d == adc_cal_pkg::ST_CAL && step_d <= `CAL_STEPS) ? step_d : 4'h0;
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      state_q <= adc_cal_pkg::ST_IDLE;
      busy_q <= 1'b0;
      calibrated_q <= 1'b0;
      cal_cnt_q <= '0;
      step_q <= '0;
      corr_code_q <= 8'h80;
      corr_mask_q <= 8'h80;
      sar_q <= '0;
      mask_q <= '0;
      edges_q <= '0;
      acc_q <= '0;
      result_q <= '0;
      valid_q <= 1'b0;
      sdo_q <= 1'b0;
      track_q <= 1'b0;
      gnd_q <= 1'b0;
      cap_q <= 4'h0;
    end else begin
      state_q <= state_d;
      busy_q <= busy_d;
      calibrated_q <= calibrated_d;
      cal_cnt_q <= cal_cnt_d;
      step_q <= step_d;
      corr_code_q <= corr_code_d;
      corr_mask_q <= corr_mask_d;
      sar_q <= sar_d;
      mask_q <= mask_d;
      edges_q <= edges_d;
      acc_q <= acc_d;
      result_q <= result_d;
      valid_q <= valid_d;
      sdo_q <= sdo_d;
      track_q <= track_d;
      gnd_q <= gnd_d;
      cap_q <= cap_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign busy_out = busy_q;
  assign serial_result_out = sdo_q;
  assign result_out = result_q;
  assign result_valid_out = valid_q;
  assign sar_code_out = sar_q;
  assign track_out = track_q;
  assign gnd_sense_sel_out = gnd_q;
  assign cap_sel_out = cap_q;
  assign cal_dac_out = corr_code_q;
  assign calibrated_out = calibrated_q;

endmodule // adc_autocal_sequencer

// ==== pkg/adc_cal_map.svh ====
// constants of the autocalibrating conversion sequencer
// assumes one system clock; all pins already synchronous to it
//
// Summary of operation
// - raising calibration request resets logic, aborts any activity, drives busy high
// - calibration starts when request falls, lasts 85,532 master clocks, then busy drops
// - strobe high during calibration puts meaningless diagnostic bits on serial output
// - calibrate offset via ground sense first, then MSB capacitor, then eight more
// - corrections kept in on-chip memory and applied to every later conversion
// - a calibration request is accepted at any moment, whatever the activity
// - before any calibration the state and accuracy are undefined
// - each sample resolved by successive approximation into a 16-bit result
// - busy high while a request is held or conversion or calibration runs, low otherwise
`ifndef ADC_CAL_MAP_SVH
`define ADC_CAL_MAP_SVH

`define CAL_MCLK_CYCLES 85532
`define CAL_CNT_W 17
`define RESULT_W 16
`define CORR_W 8
`define CAL_STEPS 4'h9
`define COEF_ADDR_W 4
`define COEF_DEPTH 16
`define OFFSET_ENTRY 4'h0
`define CONV_EDGES 5'h10
`define CORR_TOP_BITS 9

`endif

// ==== pkg/adc_cal_pkg.sv ====
// types of the autocalibrating conversion sequencer
// assumes adc_cal_map.svh supplies the numbers
package adc_cal_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_HOLD = 4'b0010,
    ST_CAL  = 4'b0100,
    ST_CONV = 4'b1000
  } seq_state_e;

endpackage

// ==== core/cal_coef_ram.sv ====
// correction memory: one write port, registered read
// assumes single clock, synchronous active-high reset of the read register only
`include "adc_cal_map.svh"

module cal_coef_ram (
  input wire logic sys_clk_in, // system clock
  input wire logic srst_in, // sync reset
  input wire logic wr_en_in, // write strobe
  input wire logic [`COEF_ADDR_W-1:0] wr_addr_in, // write entry
  input wire logic [`CORR_W-1:0] wr_data_in, // write value
  input wire logic [`COEF_ADDR_W-1:0] rd_addr_in, // read entry
  output logic [`CORR_W-1:0] rd_data_out // registered read value
);

  logic [`CORR_W-1:0] mem_q [`COEF_DEPTH];
  logic [`CORR_W-1:0] rd_q;
  logic [`CORR_W-1:0] rd_d;

  always_comb begin
    rd_d = mem_q[rd_addr_in];
  end

  always_ff @(posedge sys_clk_in) begin
    if (wr_en_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
    if (srst_in) begin
      rd_q <= '0;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign rd_data_out = rd_q;

endmodule // cal_coef_ram

// ==== dv/mclk_gen_model.sv ====
// controller side: master clock pulses on request
// assumes the bench raises run_in only around frames
module mclk_gen_model (
  input wire logic sys_clk_in, // system clock
  input wire logic run_in, // frame active
  input wire logic slow_in, // doubled phase length
  output logic mclk_out // master clock, low outside frames
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ph_q = 3'h0;
  always @(negedge sys_clk_in) begin
    ph_q <= run_in ? ph_q + 3'h1 : 3'h0;
  end
  // at least two system clocks in each phase
  assign mclk_out = slow_in ? ph_q[2] : ph_q[1];
endmodule // mclk_gen_model

// ==== dv/adc_autocal_sequencer_monitor.sv ====
// port checker of the conversion sequencer
// assumes one clock and a sync active-high reset
`include "adc_cal_map.svh"
module adc_autocal_sequencer_monitor #(
  parameter logic [`CAL_CNT_W-1:0] CAL_CYCLES = `CAL_CNT_W'(`CAL_MCLK_CYCLES)
) (
  input wire logic sys_clk_in, // clock
  input wire logic srst_in, // reset
  input wire logic cal_req_in, // request
  input wire logic sample_in, // strobe
  input wire logic mclk_in, // master clock
  input wire logic busy_out, // busy
  input wire logic result_valid_out, // result pulse
  input wire logic gnd_sense_sel_out, // offset step
  input wire logic [3:0] cap_sel_out, // cal step
  input wire logic calibrated_out // cal done
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // master clock rises since busy rose, held at zero while a request is high
  // ----------------------------------------
  logic mclk_q;
  logic [`CAL_CNT_W-1:0] cnt_q, cnt_d;
  always_comb begin
    cnt_d = cnt_q + `CAL_CNT_W'(mclk_in & ~mclk_q);
    if (!busy_out || cal_req_in) cnt_d = '0;
  end
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      mclk_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      mclk_q <= mclk_in;
      cnt_q <= cnt_d;
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  property p_req_busy; cal_req_in |=> busy_out; endproperty
  property p_req_clear; cal_req_in |=> !result_valid_out && !calibrated_out; endproperty
  property p_done; result_valid_out |-> !busy_out && $past(busy_out); endproperty
  property p_start; !busy_out && !cal_req_in && $fell(sample_in) && !$past(srst_in) |=> busy_out [*2]; endproperty
  property p_gnd; gnd_sense_sel_out |-> cap_sel_out == 4'h0 && busy_out; endproperty
  property p_order;
    $changed(cap_sel_out) && cap_sel_out != 4'h0 |-> cap_sel_out == $past(cap_sel_out) + 4'h1 && cap_sel_out <= 4'h9;
  endproperty
  property p_cal_len; $rose(calibrated_out) |-> cnt_q == CAL_CYCLES && !busy_out; endproperty
  property p_conv_len; result_valid_out |-> cnt_q == `CAL_CNT_W'(17); endproperty
  a_req_busy: assert property (p_req_busy) else $error("busy low after request");
  a_req_clear: assert property (p_req_clear) else $error("activity survived request");
  a_done: assert property (p_done) else $error("result pulse while busy");
  a_start: assert property (p_start) else $error("conversion did not start");
  a_gnd: assert property (p_gnd) else $error("ground sense outside offset step");
  a_order: assert property (p_order) else $error("capacitor step out of order");
  a_cal_len: assert property (p_cal_len) else $error("calibration length wrong");
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
  c_conv: cover property (result_valid_out);
  c_cal: cover property ($rose(calibrated_out));
  c_abort: cover property (busy_out && cal_req_in);
endmodule // adc_autocal_sequencer_monitor

bind adc_autocal_sequencer adc_autocal_sequencer_monitor #(.CAL_CYCLES(CAL_CYCLES)) mon_i (
  .sys_clk_in(sys_clk_in), .srst_in(srst_in), .cal_req_in(cal_req_in), .sample_in(sample_in),
  .mclk_in(mclk_in), .busy_out(busy_out), .result_valid_out(result_valid_out),
  .gnd_sense_sel_out(gnd_sense_sel_out), .cap_sel_out(cap_sel_out), .calibrated_out(calibrated_out));

// ==== dv/tb_top.sv ====
// self-checking bench of the conversion sequencer
// assumes mclk_gen_model as the master clock source
`include "adc_cal_map.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CAL = 100;
  logic sys_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic cal_req_in = 1'b0;
  logic sample_in = 1'b0;
  logic cmp_in = 1'b0;
  logic run = 1'b0;
  logic slow = 1'b0;
  logic mclk_w, busy_out, serial_result_out, result_valid_out, calibrated_out, track_out;
  logic [15:0] result_out, sar_code_out;
  logic [7:0] cal_dac_out;
  logic [7:0] cal_word [10];
  logic [15:0] q[$];
  integer seed = 32'hc839aea4;
  int err_total = 0;
  int comparisons = 0;
  always #2 sys_clk_in = ~sys_clk_in;
  mclk_gen_model mclk_gen_model_i (.sys_clk_in(sys_clk_in), .run_in(run), .slow_in(slow), .mclk_out(mclk_w));
  adc_autocal_sequencer #(.CAL_CYCLES(`CAL_CNT_W'(CAL))) adc_autocal_sequencer_i (
    .sys_clk_in(sys_clk_in), .srst_in(srst_in), .cal_req_in(cal_req_in), .sample_in(sample_in),
    .mclk_in(mclk_w), .cmp_in(cmp_in), .busy_out(busy_out), .serial_result_out(serial_result_out),
    .result_out(result_out), .result_valid_out(result_valid_out), .sar_code_out(sar_code_out),
    .track_out(track_out), .gnd_sense_sel_out(), .cap_sel_out(), .cal_dac_out(cal_dac_out),
    .calibrated_out(calibrated_out));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task results();
    $display("errors %0d of %0d compares", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task cal(input logic s);
    int n;
    run = 1'b0;
    sample_in = s;
    cal_req_in = 1'b1;
    repeat (2) @(negedge sys_clk_in);
    chk({15'h0, busy_out}, 16'h1);
    cal_req_in = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    n = 0;
    run = 1'b1;
    do begin
      cmp_in = 1'($random(seed));
      // eight decisions per step, msb first, make each stored correction
      if (n < 80) cal_word[n/8] = {cal_word[n/8][6:0], cmp_in};
      @(posedge mclk_w);
      n++;
      repeat (2) @(negedge sys_clk_in);
      if (s && n <= 80) chk({15'h0, serial_result_out}, {15'h0, cmp_in});
    end while (busy_out === 1'b1 && n < 200);
    run = 1'b0;
    chk(16'(n), 16'(CAL));
    chk({15'h0, calibrated_out}, 16'h1);
    chk({8'h00, cal_dac_out}, 16'h0080);
  endtask
  task conv(input logic [15:0] raw);
    logic [15:0] exp_res;
    sample_in = 1'b1;
    repeat (3) @(negedge sys_clk_in);
    chk({15'h0, track_out}, 16'h1);
    sample_in = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    chk({15'h0, busy_out}, 16'h1);
    chk(sar_code_out, 16'h8000);
    // raw minus offset minus the corrections of the kept top nine bits
    exp_res = raw - {{8{cal_word[0][7]}}, cal_word[0]};
    for (int i = 0; i < 9; i++) begin
      if (raw[15-i]) exp_res = exp_res - {{8{cal_word[i+1][7]}}, cal_word[i+1]};
    end
    q.push_back(exp_res);
    run = 1'b1;
    for (int k = 0; k < 17; k++) begin
      cmp_in = (k < 16) ? raw[15-k] : 1'($random(seed));
      @(posedge mclk_w);
      repeat (2) @(negedge sys_clk_in);
      if (k < 16) chk({15'h0, serial_result_out}, {15'h0, raw[15-k]});
    end
    run = 1'b0;
    chk({15'h0, busy_out}, 16'h0);
    chk(sar_code_out, raw);
  endtask
  // ----------------------------------------
  // result watcher: oldest expected result
  // ----------------------------------------
  always @(negedge sys_clk_in) begin
    if (result_valid_out === 1'b1) begin
      if (q.size() == 0) begin
        chk(16'h1, 16'h0);
      end else begin
        chk(result_out, q.pop_front());
      end
    end
  end
  initial begin
    #100000;
    err_total++;
    results();
  end
  initial begin
    repeat (5) @(negedge sys_clk_in);
    srst_in = 1'b0;
    @(negedge sys_clk_in);
    chk({15'h0, busy_out}, 16'h0);
    cal(1'b0);
    repeat (3) conv({9'h02c, 7'($random(seed))});
    slow = 1'b1;
    conv({9'h02c, 7'($random(seed))});
    slow = 1'b0;
    // conversion cut short by a new request
    sample_in = 1'b1;
    repeat (3) @(negedge sys_clk_in);
    sample_in = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    run = 1'b1;
    repeat (5) @(posedge mclk_w);
    @(negedge sys_clk_in);
    cal(1'b1);
    repeat (2) conv({9'h02c, 7'($random(seed))});
    repeat (4) @(negedge sys_clk_in);
    chk(16'(q.size()), 16'h0);
    results();
  end
endmodule // tb_top
